//--- macu_core.sv
`default_nettype none
module macu_core
   import macu_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        issue_valid,
   input  wire logic [31:0] instr_word,
   input  wire logic [15:0] op1,
   input  wire logic [15:0] op2,
   output logic      [39:0] sum_register,
   output macu_flags_s      flags,
   output logic             done,
   output logic             unsupported,
   output logic             ptr_upd,
   output logic      [7:0]  ptr_sel,
   output logic      [7:0]  ptr_mode
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   macu_state_s state_reg;
   macu_state_s state_next;
   macu_op_e    dec_op;
   logic [7:0]  form_byte;
   logic [7:0]  arg_byte;
   logic [7:0]  sub_byte;
   logic [7:0]  mode_byte;
   logic        form_ok;
   logic        ptr_form;
   logic [31:0] prod_uu;
   logic [40:0] prod_us;
   logic [40:0] sum_wide;
   logic [40:0] raw;
   logic        is_neg;
   logic        is_rnd;
   logic        is_uns;
   logic        is_mix;
   logic        sat_capable;
   logic        in_range;
   logic        sat_hit;
   logic        ovf;
   logic [39:0] final_val;
   logic        acc_ph;
   logic        apb_wr;
   logic        flag_wr;
   logic        mapped;
   logic [31:0] rd_val;

   assign form_byte = instr_word[31:24];
   assign arg_byte  = instr_word[23:16];
   assign sub_byte  = instr_word[15:8];
   assign mode_byte = instr_word[7:0];

   // ---------------------------------------------------------------
   // opcode decode
   // ---------------------------------------------------------------
   always_comb begin
      form_ok  = (form_byte == FORM_REG_REG) || (form_byte == FORM_REG_IND) ||
                 (form_byte == FORM_IDX_IND);
      ptr_form = (form_byte == FORM_REG_IND) || (form_byte == FORM_IDX_IND);
      dec_op   = OP_NONE;
      if (issue_valid && form_ok) begin
         case (sub_byte)
            SUB_UU:      dec_op = OP_UU;
            SUB_UU_RND:  dec_op = OP_UU_RND;
            SUB_UU_NEG:  dec_op = OP_UU_NEG;
            SUB_US:      dec_op = OP_US;
            SUB_US_RND:  dec_op = OP_US_RND;
            SUB_US_NEG:  dec_op = OP_US_NEG;
            SUB_NEG: begin
               if (form_byte == FORM_REG_REG && arg_byte == NO_OPERANDS) begin
                  dec_op = OP_NEG;
               end
            end
            SUB_NEG_RND: begin
               if (form_byte == FORM_REG_REG && arg_byte == NO_OPERANDS) begin
                  dec_op = OP_NEG_RND;
               end
            end
            SUB_PTR: begin
               if (form_byte == FORM_IDX_IND) begin
                  dec_op = OP_PTR;
               end
            end
            default: dec_op = OP_NONE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // datapath
   // ---------------------------------------------------------------
   assign prod_uu  = 32'(op1) * 32'(op2);
   assign prod_us  = 41'($signed({25'h000_0000, op1}) *
                         $signed({{25{op2[15]}}, op2}));
   assign sum_wide = {state_reg.sum_register[39], state_reg.sum_register};

   always_comb begin
      is_neg = (dec_op == OP_NEG) || (dec_op == OP_NEG_RND);
      is_rnd = (dec_op == OP_UU_RND) || (dec_op == OP_US_RND) || (dec_op == OP_NEG_RND);
      is_uns = (dec_op == OP_UU) || (dec_op == OP_UU_RND) || (dec_op == OP_UU_NEG);
      is_mix = (dec_op == OP_US) || (dec_op == OP_US_RND) || (dec_op == OP_US_NEG);
      sat_capable = is_uns || is_neg;
      raw = 41'h000_0000_0000;
      unique case (dec_op)
         OP_UU:      raw = {9'h000, prod_uu};
         OP_UU_RND:  raw = {9'h000, prod_uu} + RND_CONST;
         OP_UU_NEG:  raw = 41'h000_0000_0000 - {9'h000, prod_uu};
         OP_US:      raw = prod_us;
         OP_US_RND:  raw = prod_us + RND_CONST;
         OP_US_NEG:  raw = 41'h000_0000_0000 - prod_us;
         OP_NEG:     raw = 41'h000_0000_0000 - sum_wide;
         OP_NEG_RND: raw = 41'h000_0000_0000 - sum_wide + RND_CONST;
         default:    raw = 41'h000_0000_0000;
      endcase
      ovf      = is_neg && (raw[40] != raw[39]);
      in_range = (raw[40:31] == 10'h000) || (raw[40:31] == 10'h3FF);
      sat_hit  = state_reg.sat_en && sat_capable && !in_range;
      if (sat_hit) begin
         final_val = raw[40] ? SAT_MIN : SAT_MAX;
      end else begin
         final_val = raw[39:0];
      end
      if (is_rnd) begin
         final_val[15:0] = LOW_ZERO;
      end
   end

   // ---------------------------------------------------------------
   // register access
   // ---------------------------------------------------------------
   always_comb begin
      acc_ph  = psel && penable;
      mapped  = (paddr == OFS_CTRL) || (paddr == OFS_SUM_L) ||
                (paddr == OFS_GUARD) || (paddr == OFS_FLAGS);
      apb_wr  = acc_ph && state_reg.pready && pwrite && mapped;
      flag_wr = apb_wr && (paddr == OFS_FLAGS);
      rd_val  = RD_ZERO;
      unique case (paddr)
         OFS_CTRL:  rd_val[CTRL_SAT_BIT] = state_reg.sat_en;
         OFS_SUM_L: rd_val = state_reg.sum_register[31:0];
         OFS_GUARD: rd_val[7:0] = state_reg.sum_register[39:32];
         OFS_FLAGS: rd_val[6:0] = state_reg.flags;
         default:   rd_val = RD_ZERO;
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_next             = state_reg;
      state_next.done        = 1'b0;
      state_next.unsupported = 1'b0;
      state_next.ptr_upd     = 1'b0;
      state_next.pready      = acc_ph && !state_reg.pready;
      state_next.pslverr     = acc_ph && !state_reg.pready && !mapped;
      if (acc_ph && !state_reg.pready) begin
         state_next.prdata = mapped ? rd_val : RD_ZERO;
      end
      if (apb_wr) begin
         unique case (paddr)
            OFS_CTRL:  state_next.sat_en = pwdata[CTRL_SAT_BIT];
            OFS_SUM_L: state_next.sum_register[31:0] = pwdata;
            OFS_GUARD: state_next.sum_register[39:32] = pwdata[7:0];
            default: begin
               // sticky flags are cleared by writing ones
               if (pwdata[FLAG_SSAT_BIT]) begin
                  state_next.flags.sticky_saturation_flag = 1'b0;
               end
               if (pwdata[FLAG_SOVF_BIT]) begin
                  state_next.flags.sticky_overflow_flag = 1'b0;
               end
            end
         endcase
      end
      if (issue_valid) begin
         state_next.unsupported = (dec_op == OP_NONE);
         state_next.done        = (dec_op != OP_NONE);
         if (dec_op != OP_NONE && (ptr_form || dec_op == OP_PTR)) begin
            state_next.ptr_upd  = 1'b1;
            state_next.ptr_sel  = arg_byte;
            state_next.ptr_mode = mode_byte;
         end
      end
      if (dec_op != OP_NONE && dec_op != OP_PTR) begin
         // instruction results take priority over a register write
         state_next.sum_register = final_val;
         state_next.flags.zero_result_flag = (final_val == 40'h00_0000_0000);
         state_next.flags.negative_flag =
            (dec_op == OP_UU || dec_op == OP_UU_RND) ? 1'b0 : final_val[39];
         state_next.flags.overflow_flag     = ovf;
         state_next.flags.carry_borrow_flag =
            is_neg && (state_reg.sum_register != 40'h00_0000_0000);
         state_next.flags.extension_used_flag =
            sat_capable && (final_val[39:31] != 9'h000) &&
            (final_val[39:31] != 9'h1FF);
         if (sat_hit) begin
            state_next.flags.sticky_saturation_flag = 1'b1;
         end
         if (ovf) begin
            state_next.flags.sticky_overflow_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata       = state_reg.prdata;
   assign pready       = state_reg.pready;
   assign pslverr      = state_reg.pslverr;
   assign sum_register = state_reg.sum_register;
   assign flags        = state_reg.flags;
   assign done         = state_reg.done;
   assign unsupported  = state_reg.unsupported;
   assign ptr_upd      = state_reg.ptr_upd;
   assign ptr_sel      = state_reg.ptr_sel;
   assign ptr_mode     = state_reg.ptr_mode;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [40:0] chk_uu_sum;
   logic [40:0] chk_us_sum;
   logic [40:0] chk_neg_sum;
   logic [39:0] chk_uu_rnd;
   logic [39:0] chk_us_rnd;
   logic [39:0] chk_neg_rnd;
   logic        chk_neg_code;

   // expected rounded results; only the unsigned one is worked out apart from the datapath
   assign chk_uu_sum   = 41'(op1) * 41'(op2) + RND_CONST;
   assign chk_us_sum   = prod_us + RND_CONST;
   assign chk_neg_sum  = RND_CONST - sum_wide;
   assign chk_uu_rnd   = {chk_uu_sum[39:16], LOW_ZERO};
   assign chk_us_rnd   = {chk_us_sum[39:16], LOW_ZERO};
   assign chk_neg_rnd  = {chk_neg_sum[39:16], LOW_ZERO};
   assign chk_neg_code = (sub_byte == SUB_NEG) || (sub_byte == SUB_NEG_RND);

   uu_plain_a: assert property ((dec_op == OP_UU) && !state_reg.sat_en |=>
      sum_register == {8'h00, $past(prod_uu)})
      else $error("plain unsigned multiply result wrong");

   uu_negate_a: assert property ((dec_op == OP_UU_NEG) && !state_reg.sat_en |=>
      sum_register == 40'(40'h00_0000_0000 - {8'h00, $past(prod_uu)}))
      else $error("negated unsigned multiply result wrong");

   round_low_a: assert property (is_rnd |=> sum_register[15:0] == LOW_ZERO)
      else $error("rounding left low word set");

   uu_round_a: assert property ((dec_op == OP_UU_RND) && !state_reg.sat_en |=>
      sum_register == $past(chk_uu_rnd))
      else $error("rounding unsigned multiply result wrong");

   us_round_a: assert property ((dec_op == OP_US_RND) |=>
      sum_register == $past(chk_us_rnd))
      else $error("rounding mixed multiply result wrong");

   mixed_plain_a: assert property ((dec_op == OP_US) |=>
      sum_register == 40'($past(prod_us)))
      else $error("mixed multiply result wrong");

   mixed_neg_a: assert property ((dec_op == OP_US_NEG) |=>
      sum_register == 40'(40'h00_0000_0000 - $past(prod_us)))
      else $error("negated mixed multiply result wrong");

   negate_sum_a: assert property ((dec_op == OP_NEG) && !state_reg.sat_en |=>
      sum_register == 40'(40'h00_0000_0000 - $past(sum_register)))
      else $error("negation result wrong");

   neg_round_a: assert property ((dec_op == OP_NEG_RND) && !state_reg.sat_en |=>
      sum_register == $past(chk_neg_rnd))
      else $error("rounding negation result wrong");

   ptr_hold_a: assert property ((dec_op == OP_PTR) && !apb_wr |=>
      $stable(flags) && $stable(sum_register) && ptr_upd)
      else $error("pointer-only op changed state");

   ptr_fields_a: assert property ((dec_op == OP_PTR) |=>
      ptr_sel == $past(arg_byte) && ptr_mode == $past(mode_byte))
      else $error("pointer request fields wrong");

   mul_flags_a: assert property ((is_uns || is_mix) && !flag_wr |=>
      !flags.overflow_flag && !flags.carry_borrow_flag &&
      flags.sticky_overflow_flag == $past(flags.sticky_overflow_flag))
      else $error("multiply flags wrong");

   uu_sign_a: assert property ((dec_op == OP_UU || dec_op == OP_UU_RND) |=>
      !flags.negative_flag)
      else $error("unsigned multiply set negative flag");

   sign_copy_a: assert property (is_mix || is_neg || (dec_op == OP_UU_NEG) |=>
      flags.negative_flag == sum_register[39])
      else $error("negative flag does not follow result");

   mixed_sat_a: assert property (is_mix && !flag_wr |=>
      flags.sticky_saturation_flag == $past(flags.sticky_saturation_flag) &&
      !flags.extension_used_flag)
      else $error("mixed multiply touched saturation or extension");

   sat_clamp_a: assert property (sat_hit |=>
      flags.sticky_saturation_flag &&
      (sum_register[39:31] == 9'h000 || sum_register[39:31] == 9'h1FF))
      else $error("saturation left result out of range");

   sat_sticky_a: assert property ((dec_op != OP_NONE) && !sat_hit && !flag_wr |=>
      $stable(flags.sticky_saturation_flag))
      else $error("sticky saturation changed without saturation");

   ext_used_a: assert property (is_uns || is_neg |=>
      flags.extension_used_flag ==
      (sum_register[39:31] != 9'h000 && sum_register[39:31] != 9'h1FF))
      else $error("extension flag disagrees with guard bits");

   neg_ovf_a: assert property ((dec_op == OP_NEG) && sum_register == SUM_MOST_NEG |=>
      flags.overflow_flag && flags.sticky_overflow_flag)
      else $error("negation overflow not flagged");

   neg_ovf_clear_a: assert property (is_neg && !ovf |=> !flags.overflow_flag)
      else $error("negation overflow set without overflow");

   neg_sticky_a: assert property (is_neg && !ovf && !flag_wr |=>
      $stable(flags.sticky_overflow_flag))
      else $error("sticky overflow changed without overflow");

   neg_borrow_a: assert property (is_neg |=>
      flags.carry_borrow_flag == ($past(sum_register) != 40'h00_0000_0000))
      else $error("negation borrow wrong");

   form_refuse_a: assert property (issue_valid && !form_ok |=>
      unsupported && !done && !ptr_upd)
      else $error("unknown form byte accepted");

   reg_no_ptr_a: assert property (issue_valid && form_byte == FORM_REG_REG |=>
      !ptr_upd)
      else $error("register form asked for a pointer update");

   ind_ptr_a: assert property (issue_valid && ptr_form && dec_op != OP_NONE |=>
      ptr_upd)
      else $error("indirect form gave no pointer update");

   unit_decode_a: assert property (issue_valid && form_ok &&
      (sub_byte == SUB_UU || sub_byte == SUB_UU_NEG) |=> done)
      else $error("unsigned multiply code not executed");

   mixed_decode_a: assert property (issue_valid && form_ok &&
      (sub_byte == SUB_US || sub_byte == SUB_US_RND || sub_byte == SUB_US_NEG) |=> done)
      else $error("mixed multiply code not executed");

   neg_form_a: assert property (issue_valid && chk_neg_code && !apb_wr &&
      (form_byte != FORM_REG_REG || arg_byte != NO_OPERANDS) |=>
      unsupported && $stable(sum_register))
      else $error("negation accepted outside register form");

   round_code_a: assert property (issue_valid && form_ok && sub_byte == SUB_UU_RND |=>
      done && sum_register[15:0] == LOW_ZERO)
      else $error("rounding unsigned code not executed");

   zero_flag_a: assert property ((dec_op != OP_NONE) && (dec_op != OP_PTR) |=>
      flags.zero_result_flag == (sum_register == 40'h00_0000_0000))
      else $error("zero flag disagrees with result");

   uu_cov_c:  cover property (dec_op == OP_UU ##1 done);
   sat_cov_c: cover property (sat_hit ##1 flags.sticky_saturation_flag);
   ovf_cov_c: cover property ((dec_op == OP_NEG_RND) ##1 flags.overflow_flag);
   ptr_cov_c: cover property ((dec_op == OP_PTR) ##1 ptr_upd);
   neg_cov_c: cover property (is_neg ##1 flags.carry_borrow_flag);
endmodule // macu_core
`default_nettype wire

//--- macu_pkg.sv
`default_nettype none
package macu_pkg;
   // ---------------------------------------------------------------
   // instruction encoding
   // ---------------------------------------------------------------
   localparam logic [7:0] FORM_REG_REG = 8'hA3;
   localparam logic [7:0] FORM_REG_IND = 8'h83;
   localparam logic [7:0] FORM_IDX_IND = 8'h93;
   localparam logic [7:0] NO_OPERANDS  = 8'h00;
   localparam logic [7:0] SUB_UU       = 8'h00;
   localparam logic [7:0] SUB_UU_RND   = 8'h01;
   localparam logic [7:0] SUB_UU_NEG   = 8'h08;
   localparam logic [7:0] SUB_US       = 8'h80;
   localparam logic [7:0] SUB_US_RND   = 8'h81;
   localparam logic [7:0] SUB_US_NEG   = 8'h88;
   localparam logic [7:0] SUB_NEG      = 8'h32;
   localparam logic [7:0] SUB_NEG_RND  = 8'h72;
   localparam logic [7:0] SUB_PTR      = 8'h5A;
   // ---------------------------------------------------------------
   // arithmetic constants
   // ---------------------------------------------------------------
   localparam logic [40:0] RND_CONST = 41'h00_0000_8000;
   localparam logic [39:0] SAT_MAX   = 40'h00_7FFF_FFFF;
   localparam logic [39:0] SAT_MIN   = 40'hFF_8000_0000;
   localparam logic [39:0] SUM_MOST_NEG = 40'h80_0000_0000;
   localparam logic [15:0] LOW_ZERO  = 16'h0000;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL  = 12'h000;
   localparam logic [11:0] OFS_SUM_L = 12'h004;
   localparam logic [11:0] OFS_GUARD = 12'h008;
   localparam logic [11:0] OFS_FLAGS = 12'h00C;
   localparam int CTRL_SAT_BIT  = 0;
   localparam int FLAG_SSAT_BIT = 5;
   localparam int FLAG_SOVF_BIT = 3;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE, OP_UU, OP_UU_RND, OP_UU_NEG, OP_US, OP_US_RND, OP_US_NEG,
      OP_NEG, OP_NEG_RND, OP_PTR
   } macu_op_e;
   // bit order matches the flags register, bit 6 down to bit 0
   typedef struct packed {
      logic overflow_flag;
      logic sticky_saturation_flag;
      logic extension_used_flag;
      logic sticky_overflow_flag;
      logic carry_borrow_flag;
      logic zero_result_flag;
      logic negative_flag;
   } macu_flags_s;
   typedef struct packed {
      logic [39:0] sum_register;
      macu_flags_s flags;
      logic        sat_en;
      logic        done;
      logic        unsupported;
      logic        ptr_upd;
      logic [7:0]  ptr_sel;
      logic [7:0]  ptr_mode;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } macu_state_s;
endpackage : macu_pkg
`default_nettype wire

//--- macu_pipe_model.sv
`default_nettype none
module macu_pipe_model
   import macu_pkg::*;
(
   input  wire logic        pclk,
   output logic             issue_valid,
   output logic      [31:0] instr_word,
   output logic      [15:0] op1,
   output logic      [15:0] op2
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      issue_valid = 1'b0;
      instr_word  = 32'h0000_0000;
      op1         = 16'h0000;
      op2         = 16'h0000;
   end
   // one issue cycle, then idle with the fields scrambled
   task automatic issue(input logic [31:0] w, input logic [15:0] a, input logic [15:0] b);
      @(posedge pclk);
      issue_valid <= 1'b1;
      instr_word  <= w;
      op1         <= a;
      op2         <= b;
      @(posedge pclk);
      issue_valid <= 1'b0;
      instr_word  <= ~w;
      op1         <= ~a;
      op2         <= ~b;
   endtask
endmodule // macu_pipe_model
`default_nettype wire

//--- test_mac_unsigned_mixed_mult_negate.sv
`default_nettype none
module test_mac_unsigned_mixed_mult_negate
   import macu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, sat_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, instr_word, rd;
   logic        issue_valid, done, unsupported, ptr_upd;
   logic [15:0] op1, op2;
   logic [39:0] sum_register, exp_sum;
   logic [7:0]  ptr_sel, ptr_mode;
   macu_flags_s flags, exp_flags;
   int          err_count, checked;
   logic [7:0]  code_t [8] = '{8'h00, 8'h01, 8'h08, 8'h80, 8'h81, 8'h88, 8'h32, 8'h72};
   logic [7:0]  form_t [4] = '{8'hA3, 8'h83, 8'h93, 8'hA3};
   logic [15:0] a_t    [4] = '{16'hFFFF, 16'h8000, 16'h1234, 16'h0003};
   logic [15:0] b_t    [4] = '{16'hFFFF, 16'h8000, 16'hFEDC, 16'h0000};

   macu_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .issue_valid(issue_valid), .instr_word(instr_word), .op1(op1),
      .op2(op2), .sum_register(sum_register), .flags(flags), .done(done),
      .unsupported(unsupported), .ptr_upd(ptr_upd), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode));
   macu_pipe_model i_pipe (.pclk(pclk), .issue_valid(issue_valid), .instr_word(instr_word),
      .op1(op1), .op2(op2));

   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;

   // --------------------------------------------------
   // checking and bus tasks
   // --------------------------------------------------
   task automatic check_word(input logic [39:0] got, input logic [39:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic check_flags(input macu_flags_s got, input macu_flags_s exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t flags got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd      = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // --------------------------------------------------
   // expected sum and flags
   // --------------------------------------------------
   function automatic void model(input logic [7:0] code, input logic [15:0] a, input logic [15:0] b);
      logic signed [40:0] r, ta, tb;
      logic acc_op, uns, ovf, sat, rnd;
      acc_op = (code == 8'h32) || (code == 8'h72);
      uns = !code[7] && !acc_op;
      rnd = code[0] || (code == 8'h72);
      ta = uns ? $signed({25'd0, a}) : $signed({1'b0, a});
      tb = uns ? $signed({25'd0, b}) : $signed(b);
      r = acc_op ? 41'sd0 - $signed({exp_sum[39], exp_sum}) : ta * tb;
      if (code[3] && !acc_op) r = -r;
      if (rnd) r = r + 41'sh8000;
      ovf = acc_op && (r[40] != r[39]);
      sat = sat_en && (uns || acc_op) && (r > 41'sh7FFF_FFFF || r < -41'sh8000_0000);
      if (sat) r = r[40] ? -41'sh8000_0000 : 41'sh7FFF_FFFF;
      if (rnd) r[15:0] = 16'h0000;
      exp_flags.carry_borrow_flag = acc_op && (exp_sum != 40'h00_0000_0000);
      exp_sum = r[39:0];
      exp_flags.overflow_flag = ovf;
      exp_flags.sticky_overflow_flag |= ovf;
      exp_flags.sticky_saturation_flag |= sat;
      exp_flags.extension_used_flag = (uns || acc_op) && !(&r[39:31] || !(|r[39:31]));
      exp_flags.zero_result_flag = (r[39:0] == 40'h00_0000_0000);
      exp_flags.negative_flag = (code == 8'h00 || code == 8'h01) ? 1'b0 : r[39];
   endfunction

   task automatic do_op(input logic [31:0] w, input logic [15:0] a, input logic [15:0] b);
      logic acc_op, bad, ptr;
      acc_op = (w[15:8] == 8'h32) || (w[15:8] == 8'h72);
      bad = !(w[15:8] inside {8'h00, 8'h01, 8'h08, 8'h80, 8'h81, 8'h88, 8'h32, 8'h72, 8'h5A})
            || (acc_op && w[31:16] != 16'hA300) || !(w[31:24] inside {8'hA3, 8'h83, 8'h93})
            || (w[15:8] == 8'h5A && w[31:24] != 8'h93);
      ptr = !bad && !acc_op && (w[31:24] != 8'hA3);
      if (!bad && w[15:8] != 8'h5A) model(w[15:8], a, b);
      i_pipe.issue(w, a, b);
      #1;
      check_word(sum_register, exp_sum, "sum");
      check_flags(flags, exp_flags);
      check_word({39'd0, done}, {39'd0, !bad}, "done");
      check_word({39'd0, unsupported}, {39'd0, bad}, "unsupported");
      check_word({39'd0, ptr_upd}, {39'd0, ptr}, "ptr upd");
      if (ptr) check_word({32'd0, ptr_sel}, {32'd0, w[23:16]}, "ptr sel");
   endtask

   // every code but the pointer code in every form, negations refused outside the register form
   task automatic run_pass();
      for (int p = 0; p < 4; p++)
         for (int c = 0; c < 8; c++)
            do_op({form_t[p], form_t[p] == 8'hA3 ? 8'h00 : 8'h5C, code_t[c], 8'h0B},
                  a_t[p], b_t[p]);
   endtask

   // --------------------------------------------------
   // main sequence
   // --------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      err_count = 0;
      checked = 0;
      exp_sum = 40'h00_0000_0000;
      exp_flags = '0;
      sat_en = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      check_word(sum_register, exp_sum, "reset sum");
      $display("test reset done");
      run_pass();
      $display("test plain ops done");
      apb_xfer(1'b1, 12'h000, 32'h0000_0001);
      sat_en = 1'b1;
      run_pass();
      apb_xfer(1'b0, 12'h00C, 32'h0000_0000);
      check_word({33'd0, rd[6:0]}, {33'd0, exp_flags}, "flag reg");
      apb_xfer(1'b1, 12'h00C, 32'h0000_0028);
      exp_flags.sticky_saturation_flag = 1'b0;
      exp_flags.sticky_overflow_flag = 1'b0;
      #1;
      check_flags(flags, exp_flags);
      $display("test saturation done");
      apb_xfer(1'b1, 12'h000, 32'h0000_0000);
      sat_en = 1'b0;
      apb_xfer(1'b1, 12'h004, 32'h0000_0000);
      apb_xfer(1'b1, 12'h008, 32'h0000_0080);
      exp_sum = 40'h80_0000_0000;
      do_op(32'hA300_3200, 16'h0000, 16'h0000);
      do_op(32'h9345_5A12, 16'h1111, 16'h2222);
      check_word({32'd0, ptr_mode}, 40'h00_0000_0012, "ptr mode");
      do_op(32'hA300_C000, 16'h0002, 16'h0003);
      do_op(32'hB300_0000, 16'h0002, 16'h0003);
      do_op(32'hA300_5A00, 16'h0002, 16'h0003);
      $display("test overflow and pointer done");
      apb_xfer(1'b0, 12'h004, 32'h0000_0000);
      check_word({8'd0, rd}, {8'd0, exp_sum[31:0]}, "sum low");
      apb_xfer(1'b0, 12'h008, 32'h0000_0000);
      check_word({8'd0, rd}, {32'd0, exp_sum[39:32]}, "guard");
      apb_xfer(1'b0, 12'h010, 32'h0000_0000);
      check_word({7'd0, rerr, rd}, {7'd1, 32'h0000_0000}, "unmapped");
      $display("test register access done");
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      $display("FAIL %0t watchdog expired", $time);
      complete_run();
   end
endmodule // test_mac_unsigned_mixed_mult_negate
`default_nettype wire
